// File: wic_pkg.sv
package wic_pkg;
	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ             = 40000000;
	localparam int unsigned PALM_WINDOW_MS     = 500;
	localparam int unsigned PALM_WINDOW_CYCLES = CLK_HZ / 1000 * PALM_WINDOW_MS;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_MODE      = 8'h00;
	localparam logic [7:0] REG_SCHED     = 8'h04;
	localparam logic [7:0] REG_RETRACT   = 8'h08;
	localparam logic [7:0] REG_FORCE     = 8'h0C;
	localparam logic [7:0] REG_COMP      = 8'h10;
	localparam logic [7:0] REG_LIMITS    = 8'h14;
	localparam logic [7:0] REG_STATUS    = 8'h18;
	localparam logic [7:0] REG_LINE_MEAS = 8'h1C;

	// ------------------------------------------------------------
	// Mode and status register field positions
	// ------------------------------------------------------------
	localparam int unsigned MODE_EXT_SEL  = 0;
	localparam int unsigned MODE_PALM     = 1;
	localparam int unsigned MODE_FB_SEC   = 2;
	localparam int unsigned MODE_SEQ_EN   = 3;
	localparam int unsigned MODE_LINE_MON = 4;
	localparam int unsigned MODE_AOO_LO   = 5;
	localparam int unsigned MODE_PRES_LO  = 7;
	localparam int unsigned MODE_UNIT_LO  = 9;
	localparam int unsigned MODE_BEAT_LO  = 11;
	localparam int unsigned STAT_INVALID  = 0;
	localparam int unsigned STAT_HIGH     = 1;
	localparam int unsigned STAT_LOW      = 2;

	// ------------------------------------------------------------
	// Value limits and reset values
	// ------------------------------------------------------------
	localparam logic [6:0]  SCHED_MAX        = 7'h63;
	localparam logic [6:0]  SECOND_SCHED     = 7'h14;
	localparam logic [6:0]  RETRACT_MAX      = 7'h63;
	localparam logic [7:0]  CYL_MIN          = 8'h0A;
	localparam logic [7:0]  CYL_MAX          = 8'h64;
	localparam logic [14:0] BK_LB_MAX        = 15'h3D54;
	localparam logic [14:0] BK_PSI_MAX       = 15'h0064;
	localparam logic [14:0] BK_MA_MIN        = 15'h0028;
	localparam logic [14:0] BK_MA_MAX        = 15'h00C8;
	localparam logic [3:0]  COMP_MAX         = 4'hA;
	localparam logic [9:0]  NOMINAL_MIN      = 10'h0BB;
	localparam logic [9:0]  NOMINAL_MAX      = 10'h279;
	localparam logic [9:0]  LIMIT_MIN        = 10'h0A0;
	localparam logic [9:0]  LIMIT_MAX        = 10'h2EE;
	localparam logic [9:0]  NOMINAL_RST      = 10'h0F0;
	localparam logic [9:0]  HIGH_RST         = 10'h108;
	localparam logic [9:0]  LOW_RST          = 10'h0D8;
	localparam logic [7:0]  CYL_RST          = 8'h28;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {AOO_OFF = 2'b00, AOO_NO_RETRACT = 2'b01, AOO_RETRACT = 2'b10} wic_aoo_type;
	typedef enum logic [1:0] {PRES_OFF = 2'b00, SENSE_ONLY = 2'b01, CONTROL_ONLY = 2'b10,
		SENSE_AND_CONTROL = 2'b11} wic_pres_type;
	typedef enum logic [1:0] {UNIT_MA = 2'b00, UNIT_CAL_LB = 2'b01, UNIT_PSI = 2'b10,
		UNIT_LB = 2'b11} wic_unit_type;
	typedef enum logic [1:0] {BEAT_NONE = 2'b00, BEAT_SQUEEZE = 2'b01, BEAT_SQUEEZE_AND_WELD = 2'b10,
		BEAT_WAIT_HERE = 2'b11} wic_beat_type;
endpackage

// File: wic_palm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wic_palm_if;
	logic left_palm;
	logic right_palm;
	logic enable;
	logic fire;
	logic timing;
	modport owner (output left_palm, output right_palm, output enable, input fire, input timing);
	modport window (input left_palm, input right_palm, input enable, output fire, output timing);
endinterface
`default_nettype wire

// File: wic_palm_window.sv
`timescale 1ns/1ps
`default_nettype none
module wic_palm_window #(
	parameter int unsigned WINDOW_CYCLES = wic_pkg::PALM_WINDOW_CYCLES
) (
	// Clock and reset
	input wire logic      ref_clk,
	input wire logic      rst,
	// Palm pair
	wic_palm_if.window    palm
);
	import wic_pkg::*;

	typedef struct packed {
		logic [24:0] count;
		logic        armed;
		logic        expired;
		logic        fire;
	} wic_palm_state_type;

	wic_palm_state_type state;
	wic_palm_state_type next_state;
	logic               any_closed;
	logic               both_closed;

	always_comb begin
		next_state = state;
		any_closed = palm.left_palm | palm.right_palm;
		both_closed = palm.left_palm & palm.right_palm;
		next_state.fire = 1'b0;
		if (!palm.enable || !any_closed) begin
			// Both open again: window rearms
			next_state.armed = 1'b0;
			next_state.expired = 1'b0;
			next_state.count = '0;
		end else if (!state.armed && !state.expired) begin
			next_state.armed = 1'b1;
			next_state.count = '0;
			// Both in one cycle counts as inside the window
			if (both_closed) begin
				next_state.fire = 1'b1;
				next_state.expired = 1'b1;
				next_state.armed = 1'b0;
			end
		end else if (state.armed) begin
			if (both_closed) begin
				next_state.fire = 1'b1;
				next_state.armed = 1'b0;
				next_state.expired = 1'b1;
			end else if (state.count >= 25'(WINDOW_CYCLES - 1)) begin
				// Too late: no start until both palms are released
				next_state.armed = 1'b0;
				next_state.expired = 1'b1;
			end else begin
				next_state.count = state.count + 25'h0000001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign palm.fire = state.fire;
	assign palm.timing = state.armed;

	property p_palm_window_bound;
		@(posedge ref_clk) disable iff (rst)
		state.armed |-> state.count < 25'(WINDOW_CYCLES);
	endproperty
	a_palm_window_bound: assert property (p_palm_window_bound) else $error("palm window overran");

	property p_palm_rearm;
		@(posedge ref_clk) disable iff (rst)
		(palm.enable && !palm.left_palm && !palm.right_palm) |=> !state.armed && !state.expired;
	endproperty
	a_palm_rearm: assert property (p_palm_rearm) else $error("palm window did not rearm");
endmodule
`default_nettype wire

// File: wic_top.sv
// Behaviour
// - Internal select: first initiation runs the stored chosen schedule.
// - External select: seven inputs give schedule, above 99 clamps to 99.
// - Two-palm: both palms closing within 0.5 s starts first schedule.
// - Two-palm on: first still starts its schedule, second starts 20.
// - Feedback source setting picks primary or secondary coil.
// - Air-over-oil off/no-retract/retract; retract times only when retracting.
// - Two retract travel times, 0 to 99 line cycles each.
// - Pressure off/sense/control/both; force unit only when not off.
// - Force unit mA, calibrated lb, PSI or lb; PSI maps 4-20 mA.
// - Changing force unit invalidates stored force data in all schedules.
// - Cylinder diameter 1.0 to 10.0 inch used only in pounds unit.
// - Background valve level only in control states, range by unit.
// - Sequencer runs only when its enable is on.
// - Non-beat: momentary closure runs full sequence; only e-stop halts.
// - Beat during squeeze: opening before squeeze end terminates without weld.
// - Squeeze and weld beat: opening in weld jumps to hold.
// - Wait-here beat allows wait-here cycles; initiation as non-beat.
// - Compensation disabled or 1-10 %, phase-shift schedules only.
// - Compensation follows deviation from nominal 187 to 633 volts.
// - Line monitoring flags high and low line errors.
// - Limits 160 to 750 volts, used only with monitoring on.
`timescale 1ns/1ps
`default_nettype none
module wic_top #(
	parameter int unsigned PALM_CYCLES = wic_pkg::PALM_WINDOW_CYCLES
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [31:0] reg_rdata,
	// Initiation inputs
	input  wire logic        first_initiation,
	input  wire logic        second_initiation,
	input  wire logic        left_palm_initiation,
	input  wire logic        right_palm_initiation,
	input  wire logic [6:0]  schedule_select_inputs,
	input  wire logic        emergency_stop_open,
	// Sequence progress from weld engine
	input  wire logic        in_squeeze,
	input  wire logic        in_weld,
	input  wire logic        phase_shift_schedule,
	// Line sensing
	input  wire logic [9:0]  line_voltage,
	// Start and beat outputs
	output var  logic        start_request,
	output var  logic [6:0]  start_schedule,
	output var  logic        sequence_abort,
	output var  logic        weld_cut_to_hold,
	output var  logic        wait_here_allowed,
	output var  logic        sequencer_run,
	// Configuration outputs
	output var  logic        feedback_secondary,
	output var  logic        retract_active,
	output var  logic [6:0]  retract_open_cycles,
	output var  logic [6:0]  retract_close_cycles,
	output var  logic        force_unit_active,
	output var  logic        cylinder_used,
	output var  logic        background_valve_active,
	output var  logic [14:0] background_valve_level,
	output var  logic        line_comp,
	output var  logic [3:0]  line_comp_max,
	output var  logic signed [10:0] line_deviation,
	output var  logic        high_line_error,
	output var  logic        low_line_error,
	output var  logic        schedule_force_invalid
);
	import wic_pkg::*;

	typedef struct packed {
		logic [15:0] mode;
		logic [6:0]  chosen;
		logic [6:0]  ret_open;
		logic [6:0]  ret_close;
		logic [7:0]  cyl;
		logic [14:0] bk;
		logic [3:0]  comp;
		logic [9:0]  nominal;
		logic [9:0]  high;
		logic [9:0]  low;
		logic        invalid;
		logic        hi_err;
		logic        lo_err;
		logic        first_d;
		logic        second_d;
		logic        seq_live;
		logic        start;
		logic [6:0]  sched;
		logic        abort;
		logic        cut;
		logic [31:0] rdata;
		logic        wait_here;
		logic        fb_sec;
		logic        ret_on;
		logic [6:0]  ret_o;
		logic [6:0]  ret_c;
		logic        unit_on;
		logic        cyl_on;
		logic        bk_on;
		logic [14:0] bk_out;
		logic        comp_on;
		logic signed [10:0] dev;
	} wic_state_type;

	wic_state_type s;
	wic_state_type next_s;
	wic_palm_if    palm_bus ();

	wic_unit_type unit;
	wic_beat_type beat;
	logic [6:0]   first_sched;
	logic [14:0]  bk_lo;
	logic [14:0]  bk_hi;
	logic [14:0]  bk_w;

	// ------------------------------------------------------------
	// Palm window
	// ------------------------------------------------------------
	assign palm_bus.left_palm = left_palm_initiation;
	assign palm_bus.right_palm = right_palm_initiation;
	assign palm_bus.enable = s.mode[MODE_PALM];

	wic_palm_window #(.WINDOW_CYCLES(PALM_CYCLES)) u_palm (
		.ref_clk (ref_clk),
		.rst     (rst),
		.palm    (palm_bus)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		unit = wic_unit_type'(s.mode[MODE_UNIT_LO +: 2]);
		beat = wic_beat_type'(s.mode[MODE_BEAT_LO +: 2]);
		bk_lo = (unit == UNIT_MA) ? BK_MA_MIN : 15'h0000;
		unique case (unit)
			UNIT_MA: bk_hi = BK_MA_MAX;
			UNIT_PSI: bk_hi = BK_PSI_MAX;
			UNIT_CAL_LB, UNIT_LB: bk_hi = BK_LB_MAX;
		endcase
		// Bit 0 of the select inputs is the lowest-numbered input
		if (s.mode[MODE_EXT_SEL]) begin
			first_sched = (schedule_select_inputs > SCHED_MAX) ? SCHED_MAX : schedule_select_inputs;
		end else begin
			first_sched = s.chosen;
		end
		bk_w = reg_wdata[14:0];

		next_s.first_d = first_initiation;
		next_s.second_d = second_initiation;
		next_s.start = 1'b0;
		next_s.abort = 1'b0;
		next_s.cut = 1'b0;
		// Closure edges start; highest priority to the first input
		if (!emergency_stop_open) begin
			if (first_initiation && !s.first_d) begin
				next_s.start = 1'b1;
				next_s.sched = first_sched;
			end else if (second_initiation && !s.second_d) begin
				next_s.start = 1'b1;
				next_s.sched = SECOND_SCHED;
			end else if (palm_bus.fire) begin
				next_s.start = 1'b1;
				next_s.sched = first_sched;
			end
		end
		// Only emergency stop halts in non-beat and wait-here
		if (emergency_stop_open) begin
			next_s.abort = 1'b1;
		end else if (!first_initiation && !second_initiation
				&& !(left_palm_initiation && right_palm_initiation)) begin
			if ((beat == BEAT_SQUEEZE || beat == BEAT_SQUEEZE_AND_WELD) && in_squeeze) begin
				next_s.abort = 1'b1;
			end
			if (beat == BEAT_SQUEEZE_AND_WELD && in_weld) begin
				next_s.cut = 1'b1;
			end
		end
		next_s.seq_live = s.mode[MODE_SEQ_EN];

		// Line limits act only while monitoring
		next_s.hi_err = s.mode[MODE_LINE_MON] && (line_voltage > s.high);
		next_s.lo_err = s.mode[MODE_LINE_MON] && (line_voltage < s.low);

		if (reg_wr) begin
			unique case (reg_addr)
				REG_MODE: begin
					next_s.mode = reg_wdata[15:0];
					if (reg_wdata[MODE_UNIT_LO +: 2] != s.mode[MODE_UNIT_LO +: 2]) begin
						next_s.invalid = 1'b1;
					end
				end
				REG_SCHED: if (reg_wdata[6:0] <= SCHED_MAX) next_s.chosen = reg_wdata[6:0];
				REG_RETRACT: begin
					if (reg_wdata[6:0] <= RETRACT_MAX) next_s.ret_open = reg_wdata[6:0];
					if (reg_wdata[14:8] <= RETRACT_MAX) next_s.ret_close = reg_wdata[14:8];
				end
				REG_FORCE: begin
					if (reg_wdata[7:0] >= CYL_MIN && reg_wdata[7:0] <= CYL_MAX) begin
						next_s.cyl = reg_wdata[7:0];
					end
					bk_w = reg_wdata[30:16];
					if (bk_w >= bk_lo && bk_w <= bk_hi) next_s.bk = bk_w;
				end
				REG_COMP: begin
					if (reg_wdata[3:0] <= COMP_MAX) next_s.comp = reg_wdata[3:0];
					if (reg_wdata[25:16] >= NOMINAL_MIN && reg_wdata[25:16] <= NOMINAL_MAX) begin
						next_s.nominal = reg_wdata[25:16];
					end
				end
				REG_LIMITS: begin
					if (reg_wdata[9:0] >= LIMIT_MIN && reg_wdata[9:0] <= LIMIT_MAX) next_s.high = reg_wdata[9:0];
					if (reg_wdata[25:16] >= LIMIT_MIN && reg_wdata[25:16] <= LIMIT_MAX) begin
						next_s.low = reg_wdata[25:16];
					end
				end
				REG_STATUS: if (reg_wdata[STAT_INVALID]) next_s.invalid = 1'b0;
				default: ;
			endcase
		end

		// Decodes follow the settings being stored, so every output is a flop
		next_s.wait_here = (next_s.mode[MODE_BEAT_LO +: 2] == BEAT_WAIT_HERE);
		next_s.fb_sec = next_s.mode[MODE_FB_SEC];
		next_s.ret_on = (next_s.mode[MODE_AOO_LO +: 2] == AOO_RETRACT);
		next_s.ret_o = next_s.ret_on ? next_s.ret_open : 7'h00;
		next_s.ret_c = next_s.ret_on ? next_s.ret_close : 7'h00;
		next_s.unit_on = (next_s.mode[MODE_PRES_LO +: 2] != PRES_OFF);
		next_s.cyl_on = next_s.unit_on && (next_s.mode[MODE_UNIT_LO +: 2] == UNIT_LB);
		next_s.bk_on = next_s.mode[MODE_PRES_LO + 1];
		next_s.bk_out = next_s.bk_on ? next_s.bk : 15'h0000;
		next_s.comp_on = (next_s.comp != 4'h0) && phase_shift_schedule;
		next_s.dev = 11'(signed'({1'b0, line_voltage}) - signed'({1'b0, next_s.nominal}));
		next_s.rdata = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_MODE: next_s.rdata = {16'h0000, s.mode};
				REG_SCHED: next_s.rdata = {25'h0000000, s.chosen};
				REG_RETRACT: next_s.rdata = {17'h00000, s.ret_close, 1'b0, s.ret_open};
				REG_FORCE: next_s.rdata = {1'b0, s.bk, 8'h00, s.cyl};
				REG_COMP: next_s.rdata = {6'h00, s.nominal, 12'h000, s.comp};
				REG_LIMITS: next_s.rdata = {6'h00, s.low, 6'h00, s.high};
				REG_STATUS: next_s.rdata = {29'h00000000, s.lo_err, s.hi_err, s.invalid};
				REG_LINE_MEAS: next_s.rdata = {22'h000000, line_voltage};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s <= '0;
			s.cyl <= CYL_RST;
			s.nominal <= NOMINAL_RST;
			s.high <= HIGH_RST;
			s.low <= LOW_RST;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all flop-driven
	// ------------------------------------------------------------
	always_comb begin
		reg_rdata = s.rdata;
		start_request = s.start;
		start_schedule = s.sched;
		sequence_abort = s.abort;
		weld_cut_to_hold = s.cut;
		wait_here_allowed = s.wait_here;
		sequencer_run = s.seq_live;
		feedback_secondary = s.fb_sec;
		retract_active = s.ret_on;
		retract_open_cycles = s.ret_o;
		retract_close_cycles = s.ret_c;
		force_unit_active = s.unit_on;
		cylinder_used = s.cyl_on;
		background_valve_active = s.bk_on;
		background_valve_level = s.bk_out;
		line_comp = s.comp_on;
		line_comp_max = s.comp;
		line_deviation = s.dev;
		high_line_error = s.hi_err;
		low_line_error = s.lo_err;
		schedule_force_invalid = s.invalid;
	end

	property p_ext_clamp;
		@(posedge ref_clk) disable iff (rst)
		(s.mode[MODE_EXT_SEL] && first_initiation && !s.first_d && !emergency_stop_open)
			|=> start_request && start_schedule <= SCHED_MAX;
	endproperty
	a_ext_clamp: assert property (p_ext_clamp) else $error("external schedule not clamped");

	property p_second_20;
		@(posedge ref_clk) disable iff (rst)
		(second_initiation && !s.second_d && !first_initiation && !emergency_stop_open)
			|=> start_request && start_schedule == SECOND_SCHED;
	endproperty
	a_second_20: assert property (p_second_20) else $error("second initiation not schedule 20");

	property p_unit_invalid;
		@(posedge ref_clk) disable iff (rst)
		(reg_wr && reg_addr == REG_MODE && reg_wdata[10:9] != s.mode[10:9]) |=> schedule_force_invalid;
	endproperty
	a_unit_invalid: assert property (p_unit_invalid) else $error("unit change not flagged");

	property p_retract_hidden;
		@(posedge ref_clk) disable iff (rst)
		!retract_active |-> retract_open_cycles == 7'h00 && retract_close_cycles == 7'h00;
	endproperty
	a_retract_hidden: assert property (p_retract_hidden) else $error("retract time active");

	property p_retract_range;
		@(posedge ref_clk) disable iff (rst)
		s.ret_open <= RETRACT_MAX && s.ret_close <= RETRACT_MAX;
	endproperty
	a_retract_range: assert property (p_retract_range) else $error("retract time out of range");

	property p_line_high;
		@(posedge ref_clk) disable iff (rst)
		(s.mode[MODE_LINE_MON] && line_voltage > s.high && !(reg_wr)) |=> high_line_error;
	endproperty
	a_line_high: assert property (p_line_high) else $error("high line not flagged");

	property p_line_off;
		@(posedge ref_clk) disable iff (rst)
		!s.mode[MODE_LINE_MON] |=> !low_line_error && !high_line_error;
	endproperty
	a_line_off: assert property (p_line_off) else $error("line error while monitor off");

	property p_weld_cut;
		@(posedge ref_clk) disable iff (rst)
		(s.mode[12:11] == 2'b10 && in_weld && !first_initiation && !second_initiation
			&& !left_palm_initiation && !emergency_stop_open) |=> weld_cut_to_hold;
	endproperty
	a_weld_cut: assert property (p_weld_cut) else $error("weld not cut to hold");

	property p_no_beat;
		@(posedge ref_clk) disable iff (rst)
		(s.mode[12:11] == 2'b00 && !emergency_stop_open) |=> !sequence_abort && !weld_cut_to_hold;
	endproperty
	a_no_beat: assert property (p_no_beat) else $error("non-beat abort without stop");
endmodule
`default_nettype wire

// File: wic_operator.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Operator switches and line sensing
// ------------------------------------------------------------
module wic_operator (
	// Clock
	input  wire logic       ref_clk,
	// Bench commands
	input  wire logic [3:0] press,
	input  wire logic [9:0] volts,
	// Pins toward the block
	output var  logic       first_initiation,
	output var  logic       second_initiation,
	output var  logic       left_palm_initiation,
	output var  logic       right_palm_initiation,
	output var  logic [9:0] line_voltage
);
	// Switches move only on a clock edge, like a debounced input
	always_ff @(posedge ref_clk) begin
		first_initiation      <= press[0];
		second_initiation     <= press[1];
		left_palm_initiation  <= press[2];
		right_palm_initiation <= press[3];
		line_voltage          <= volts;
	end
endmodule
`default_nettype wire

// File: weld_initiation_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module weld_initiation_config_bench;
	import wic_pkg::*;
	logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [3:0]  press = 4'h0;
	logic [9:0]  volts = 10'h0F0, lv;
	logic [6:0]  sel = 7'h00, start_schedule, r_open, r_close, v;
	logic        in_squeeze = 1'b0, in_weld = 1'b0, fi, si, lp, rp;
	logic        start_request, sequence_abort, weld_cut_to_hold, sequencer_run, hi_err, lo_err;
	logic [31:0] reads[$], starts[$];
	int          miscompares = 0, samples_checked = 0;
	logic        estop = 1'b0, phase = 1'b0;
	logic [14:0] bkl;
	logic [3:0]  lcm;
	logic [10:0] dev;
	wire  [7:0]  fl;

	wic_operator op_u (.ref_clk(ref_clk), .press(press), .volts(volts), .first_initiation(fi),
		.second_initiation(si), .left_palm_initiation(lp), .right_palm_initiation(rp), .line_voltage(lv));
	wic_top #(.PALM_CYCLES(100)) dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.first_initiation(fi), .second_initiation(si), .left_palm_initiation(lp),
		.right_palm_initiation(rp), .schedule_select_inputs(sel), .emergency_stop_open(estop),
		.in_squeeze(in_squeeze), .in_weld(in_weld), .phase_shift_schedule(phase), .line_voltage(lv),
		.start_request(start_request), .start_schedule(start_schedule), .sequence_abort(sequence_abort),
		.weld_cut_to_hold(weld_cut_to_hold), .wait_here_allowed(fl[0]), .sequencer_run(sequencer_run),
		.feedback_secondary(fl[1]), .retract_active(fl[2]), .retract_open_cycles(r_open),
		.retract_close_cycles(r_close), .force_unit_active(fl[3]), .cylinder_used(fl[4]),
		.background_valve_active(fl[5]), .background_valve_level(bkl), .line_comp(fl[6]), .line_comp_max(lcm),
		.line_deviation(dev), .high_line_error(hi_err), .low_line_error(lo_err), .schedule_force_invalid(fl[7]));

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reads.push_back(exp);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	// Closes one switch briefly and notes the start it must cause
	task automatic pulse(input int b, input logic [6:0] exp);
		starts.push_back({25'h0000000, exp});
		@(posedge ref_clk);
		press[b] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		press[b] <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic palms(input int gap, input bit fires);
		if (fires) starts.push_back(32'h0000002A);
		@(posedge ref_clk);
		press[2] <= 1'b1;
		repeat (gap) @(posedge ref_clk);
		press[3] <= 1'b1;
		repeat (5) @(posedge ref_clk);
		press[3:2] <= 2'b00;
		repeat (4) @(posedge ref_clk);
	endtask

	// Result watcher: every read answer and every start is matched to the oldest note
	always @(posedge ref_clk) begin
		if (rd_seen && reads.size() > 0) chk("reg_rdata", reads.pop_front(), reg_rdata);
		if (start_request === 1'b1) begin
			if (starts.size() == 0) chk("start_request", 32'h0, 32'h1);
			else chk("start_schedule", starts.pop_front(), {25'h0000000, start_schedule});
		end
		rd_seen <= reg_rd;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		finish_test();
	end

	initial begin
		void'($urandom(32'h3826));
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		rd(REG_LIMITS, {6'h00, LOW_RST, 6'h00, HIGH_RST});
		rd(REG_COMP, {6'h00, NOMINAL_RST, 16'h0000});
		rd(8'h20, 32'h0);
		$display("test reset done");
		wr(REG_SCHED, 32'h0000002A);
		wr(REG_SCHED, 32'h00000064);
		pulse(0, 7'h2A);
		$display("test internal select done");
		wr(REG_MODE, 32'h1 << MODE_EXT_SEL);
		for (int i = 0; i < 7; i++) begin
			v = (i == 0) ? 7'h63 : (i == 1) ? 7'h64 : (i == 2) ? 7'h7F : 7'($urandom % 128);
			sel <= v;
			pulse(0, (v > SCHED_MAX) ? SCHED_MAX : v);
		end
		$display("test external select done");
		wr(REG_MODE, 32'h1 << MODE_PALM);
		pulse(1, SECOND_SCHED);
		pulse(0, 7'h2A);
		palms(10, 1'b1);
		palms(150, 1'b0);
		$display("test two palm done");
		for (int b = 1; b < 3; b++) begin
			wr(REG_MODE, 32'(b) << MODE_BEAT_LO);
			starts.push_back(32'h0000002A);
			press[0]   <= 1'b1;
			in_squeeze <= (b == 1);
			in_weld    <= (b == 2);
			repeat (6) @(posedge ref_clk);
			chk("beat held", 32'h0, {30'h0, weld_cut_to_hold, sequence_abort});
			press[0] <= 1'b0;
			repeat (4) @(posedge ref_clk);
			chk("beat open", 32'(b), {30'h0, weld_cut_to_hold, sequence_abort});
			in_squeeze <= 1'b0;
			in_weld    <= 1'b0;
		end
		$display("test beat done");
		wr(REG_RETRACT, 32'h00000563);
		wr(REG_MODE, 32'h1 << MODE_AOO_LO);
		chk("retract_open_cycles", 32'h0, {25'h0000000, r_open});
		wr(REG_MODE, (32'h2 << MODE_AOO_LO) | (32'h1 << MODE_SEQ_EN));
		chk("retract times", {18'h00000, 7'h05, 7'h63}, {18'h00000, r_close, r_open});
		chk("config flags", 32'h04, {24'h000000, fl});
		chk("sequencer_run", 32'h1, {31'h0, sequencer_run});
		$display("test retract done");
		wr(REG_MODE, 32'h2 << MODE_UNIT_LO);
		rd(REG_STATUS, 32'h1);
		wr(REG_STATUS, 32'h1);
		rd(REG_STATUS, 32'h0);
		$display("test unit done");
		// Pounds, control only, secondary coil, wait-here beat
		wr(REG_MODE, 32'h00001F04);
		wr(REG_FORCE, {1'b0, BK_LB_MAX, 8'h00, CYL_MAX});
		wr(REG_FORCE, {1'b0, 15'h3D55, 8'h00, 8'h09});
		wr(REG_COMP, {6'h00, NOMINAL_MIN, 12'h000, COMP_MAX});
		wr(REG_COMP, 32'h0000000B);
		phase <= 1'b1;
		rd(REG_FORCE, {1'b0, BK_LB_MAX, 8'h00, CYL_MAX});
		rd(REG_COMP, {6'h00, NOMINAL_MIN, 12'h000, COMP_MAX});
		chk("config flags", 32'hFB, {24'h000000, fl});
		chk("valve and comp", {1'b0, BK_LB_MAX, 12'h000, COMP_MAX}, {1'b0, bkl, 12'h000, lcm});
		chk("line_deviation", 32'h00000035, {21'h000000, dev});
		$display("test config done");
		wr(REG_MODE, 32'h1 << MODE_LINE_MON);
		volts <= 10'h12C;
		repeat (5) @(posedge ref_clk);
		chk("line errors high", 32'h1, {30'h0, lo_err, hi_err});
		volts <= 10'h0C8;
		repeat (5) @(posedge ref_clk);
		chk("line errors low", 32'h2, {30'h0, lo_err, hi_err});
		rd(REG_LINE_MEAS, 32'h000000C8);
		$display("test line monitor done");
		estop <= 1'b1;
		press[0] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("sequence_abort", 32'h1, {31'h0, sequence_abort});
		estop <= 1'b0;
		press[0] <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("pending notes", 32'h0, 32'(starts.size() + reads.size()));
		$display("test stop done");
		repeat (4) @(posedge ref_clk);
		finish_test();
	end
endmodule
`default_nettype wire
